// >>> verilog/rws_regs.vh
// register offsets, field positions and timing constants of the receive wake/sniff controller
`ifndef RWS_REGS_VH
`define RWS_REGS_VH

// per-configuration registers, configuration B sits at RWS_CFGB_BASE
`define RWS_CFGB_BASE 8'h40
`define RWS_CTL 4'h0
`define RWS_SNIFF 4'h1
`define RWS_ENERGY 4'h2
`define RWS_RXDWELL 4'h3
`define RWS_CODEDWELL 4'h4
`define RWS_INTERVAL 4'h5
`define RWS_PATTERN 4'h6
`define RWS_PKTLEN 4'h7
`define RWS_RATE 4'h8
// global registers
`define RWS_CMD 8'h80
`define RWS_STATUS 8'h84
`define RWS_CCA 8'h88
`define RWS_BUF0 8'h90

// control register fields
`define RWS_MODE_LSB 0
`define RWS_CDREN_BIT 2
`define RWS_TWOSTAGE_BIT 3
`define RWS_THR_LSB 4
`define RWS_WLEN_LSB 8
`define RWS_ILEN_LSB 16

// receive modes
`define RWS_MODE_CONT 2'h0
`define RWS_MODE_ENERGY 2'h1
`define RWS_MODE_PATTERN 2'h2

// command codes
`define RWS_CMD_STANDBY 2'h0
`define RWS_CMD_RECEIVE 2'h1
`define RWS_CMD_SNIFF 2'h2
`define RWS_CMD_CFG_BIT 2

// sniff configuration value that arms autonomous cycling
`define RWS_SNIFF_ON 8'h03

// reset values
`define RWS_CTL_RST 32'h0000_0000
`define RWS_RATE_RST 32'h0000_0010
`define RWS_CCA_RST 32'h0000_0100

// oversampling ratio of the correlator
`define RWS_OVERSAMPLE 8
// dwell and interval unit
`define RWS_CLK_NS 10
`define RWS_DWELL_TICK_NS 100000

`endif

// >>> verilog/rws_corr.v
// oversampling pattern correlator, 8 samples per bit, up to 32 bits
`timescale 1ns/1ps
`include "rws_regs.vh"
module rws_corr (
  sys_clk,
  arst_n,
  clear,
  sampleEn,
  sample,
  pattern,
  patLen,
  thr,
  match
);
  input wire sys_clk;
  input wire arst_n;
  input wire clear;
  input wire sampleEn;
  input wire sample;
  input wire [31:0] pattern;
  input wire [5:0] patLen;
  input wire [3:0] thr;
  output reg match;

  reg [255:0] winReg;
  wire [31:0] bitOk;

  function [3:0] popCount;
    input [7:0] v;
    integer k;
    begin
      popCount = 4'h0;
      for (k = 0; k < 8; k = k + 1) begin
        popCount = popCount + {3'h0, v[k]};
      end
    end
  endfunction

  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1) begin : gBit
      // nrz compare word: the expected bit held for all 8 samples
      wire [7:0] agree = winReg[8*i+7:8*i] ~^ {`RWS_OVERSAMPLE{pattern[i]}};
      assign bitOk[i] = (i >= patLen) || (popCount(agree) >= thr);
    end
  endgenerate

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      winReg <= 256'h0;
      match <= 1'b0;
    end else if (clear) begin
      winReg <= 256'h0;
      match <= 1'b0;
    end else begin
      match <= sampleEn && (&bitOk) && (patLen != 6'h0);
      if (sampleEn) begin
        winReg <= {winReg[254:0], sample};
      end
    end
  end
endmodule

// >>> verilog/rws_ctrl.v
// receive wake and sniff controller with axi4-lite register slave
//
// Contract
// - two configuration sets A and B, fully independent settings.
// - three sniff interval timers: config A, config B, clear channel assessment.
// - per-configuration timers bound receiver on time in each sniff cycle.
// - mode 00 gives continuous receive with recovered clock/data until next command.
// - mode 01 wakes when signal strength exceeds energy threshold.
// - receive dwell bounds search; dwell 0x00 takes a single energy sample.
// - clock recovery stays off until energy threshold reached.
// - after energy, search joined wake pattern and chip id, up to 32 bits.
// - code dwell limits post-energy pattern search, expiry returns to sniff.
// - on match interrupt at once or buffer packet first when length nonzero.
// - mode 10 oversamples data against pattern with per-bit threshold.
// - wake-on-pattern: single sequence, or wake pattern then chip id.
// - receive dwell bounds wake pattern search.
// - code dwell starts on wake match, restarts on every further match.
// - both dwells expired without target returns to standby.
// - sniff config 0x03 with sniff command re-arms receive at each interval.
// - A and B use own sniff interval and dwell values.
// - A wins a timer collision; B cycle queued until A completes.
// - correlator samples demodulator output at eight times the data rate.
`timescale 1ns/1ps
`include "rws_regs.vh"
module rws_ctrl #(
  parameter [23:0] DWELL_TICK_CYCLES = `RWS_DWELL_TICK_NS / `RWS_CLK_NS
) (
  sys_clk,
  arst_n,
  s_axi_awaddr,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready,
  rssiLevel,
  demodData,
  irqOut,
  rxEnable,
  cdrEnable,
  recoveredClockPin,
  recoveredDataPin,
  activeCfg,
  ccaStrobe
);
  input wire sys_clk;
  input wire arst_n;
  input wire [7:0] s_axi_awaddr;
  input wire s_axi_awvalid;
  output reg s_axi_awready;
  input wire [31:0] s_axi_wdata;
  input wire [3:0] s_axi_wstrb;
  input wire s_axi_wvalid;
  output reg s_axi_wready;
  output reg [1:0] s_axi_bresp;
  output reg s_axi_bvalid;
  input wire s_axi_bready;
  input wire [7:0] s_axi_araddr;
  input wire s_axi_arvalid;
  output reg s_axi_arready;
  output reg [31:0] s_axi_rdata;
  output reg [1:0] s_axi_rresp;
  output reg s_axi_rvalid;
  input wire s_axi_rready;
  input wire [7:0] rssiLevel;
  input wire demodData;
  output reg irqOut;
  output reg rxEnable;
  output reg cdrEnable;
  output reg recoveredClockPin;
  output reg recoveredDataPin;
  output reg activeCfg;
  output reg ccaStrobe;

  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_CONT = 7'h02;
  localparam [6:0] S_SEARCH = 7'h04;
  localparam [6:0] S_CODE = 7'h08;
  localparam [6:0] S_BUF = 7'h10;
  localparam [6:0] S_DONE = 7'h20;
  localparam [6:0] S_WAIT = 7'h40;
  localparam [31:0] RATE_RST_W = `RWS_RATE_RST;
  localparam [31:0] CCA_RST_W = `RWS_CCA_RST;

  // per-configuration register arrays, index 0 is A, 1 is B
  reg [31:0] ctlReg [0:1];
  reg [7:0] sniffReg [0:1];
  reg [7:0] energyReg [0:1];
  reg [7:0] rxDwellReg [0:1];
  reg [7:0] codeDwellReg [0:1];
  reg [15:0] intervalReg [0:1];
  reg [31:0] patternReg [0:1];
  reg [7:0] pktLenReg [0:1];
  reg [15:0] rateReg [0:1];
  reg [15:0] ccaReg;

  // axi write side
  reg [7:0] awAddrReg;
  reg [31:0] wDataReg;
  reg [3:0] wStrbReg;
  reg cmdStb;
  reg [7:0] cmdData;
  wire [31:0] wMask = {{8{wStrbReg[3]}}, {8{wStrbReg[2]}}, {8{wStrbReg[1]}}, {8{wStrbReg[0]}}};
  wire wrGo = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire wrCfgHit = !awAddrReg[7] && (awAddrReg[5:2] <= `RWS_RATE) && (awAddrReg[1:0] == 2'h0);
  wire wrCfg = awAddrReg[6];
  wire wrCmd = awAddrReg == `RWS_CMD;
  wire wrCca = awAddrReg == `RWS_CCA;
  integer c;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      awAddrReg <= 8'h00;
      wDataReg <= 32'h0;
      wStrbReg <= 4'h0;
      cmdStb <= 1'b0;
      cmdData <= 8'h00;
      ccaReg <= CCA_RST_W[15:0];
      for (c = 0; c < 2; c = c + 1) begin
        ctlReg[c] <= `RWS_CTL_RST;
        sniffReg[c] <= 8'h00;
        energyReg[c] <= 8'h00;
        rxDwellReg[c] <= 8'h00;
        codeDwellReg[c] <= 8'h00;
        intervalReg[c] <= 16'h0000;
        patternReg[c] <= 32'h0;
        pktLenReg[c] <= 8'h00;
        rateReg[c] <= RATE_RST_W[15:0];
      end
    end else begin
      cmdStb <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        awAddrReg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wDataReg <= s_axi_wdata;
        wStrbReg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wrGo) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wrCfgHit || wrCmd || wrCca) ? 2'h0 : 2'h2;
        if (wrCmd) begin
          cmdStb <= 1'b1;
          cmdData <= wDataReg[7:0];
        end
        if (wrCca) begin
          ccaReg <= (ccaReg & ~wMask[15:0]) | (wDataReg[15:0] & wMask[15:0]);
        end
        if (wrCfgHit) begin
          case (awAddrReg[5:2])
            `RWS_CTL: ctlReg[wrCfg] <= (ctlReg[wrCfg] & ~wMask) | (wDataReg & wMask);
            `RWS_SNIFF: sniffReg[wrCfg] <= (sniffReg[wrCfg] & ~wMask[7:0]) | (wDataReg[7:0] & wMask[7:0]);
            `RWS_ENERGY: energyReg[wrCfg] <= (energyReg[wrCfg] & ~wMask[7:0]) | (wDataReg[7:0] & wMask[7:0]);
            `RWS_RXDWELL: rxDwellReg[wrCfg] <= (rxDwellReg[wrCfg] & ~wMask[7:0]) | (wDataReg[7:0] & wMask[7:0]);
            `RWS_CODEDWELL: codeDwellReg[wrCfg] <= (codeDwellReg[wrCfg] & ~wMask[7:0]) | (wDataReg[7:0] & wMask[7:0]);
            `RWS_INTERVAL: intervalReg[wrCfg] <= (intervalReg[wrCfg] & ~wMask[15:0]) | (wDataReg[15:0] & wMask[15:0]);
            `RWS_PATTERN: patternReg[wrCfg] <= (patternReg[wrCfg] & ~wMask) | (wDataReg & wMask);
            `RWS_PKTLEN: pktLenReg[wrCfg] <= (pktLenReg[wrCfg] & ~wMask[7:0]) | (wDataReg[7:0] & wMask[7:0]);
            default: rateReg[wrCfg] <= (rateReg[wrCfg] & ~wMask[15:0]) | (wDataReg[15:0] & wMask[15:0]);
          endcase
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // control state
  reg [6:0] state;
  reg cur;
  reg sniffing;
  reg pendA;
  reg pendB;
  reg [15:0] timerA;
  reg [15:0] timerB;
  reg [15:0] ccaCnt;
  reg [7:0] dwellCnt;
  reg [7:0] codeCnt;
  reg [7:0] bufCnt;
  reg [127:0] bufReg;
  reg cdrOn;

  // read side
  reg [31:0] rdWord;
  reg rdOk;
  wire rdCfg = s_axi_araddr[6];
  always @* begin
    rdWord = 32'h0;
    rdOk = 1'b1;
    if (!s_axi_araddr[7] && s_axi_araddr[1:0] == 2'h0 && s_axi_araddr[5:2] <= `RWS_RATE) begin
      case (s_axi_araddr[5:2])
        `RWS_CTL: rdWord = ctlReg[rdCfg];
        `RWS_SNIFF: rdWord = {24'h0, sniffReg[rdCfg]};
        `RWS_ENERGY: rdWord = {24'h0, energyReg[rdCfg]};
        `RWS_RXDWELL: rdWord = {24'h0, rxDwellReg[rdCfg]};
        `RWS_CODEDWELL: rdWord = {24'h0, codeDwellReg[rdCfg]};
        `RWS_INTERVAL: rdWord = {16'h0, intervalReg[rdCfg]};
        `RWS_PATTERN: rdWord = patternReg[rdCfg];
        `RWS_PKTLEN: rdWord = {24'h0, pktLenReg[rdCfg]};
        default: rdWord = {16'h0, rateReg[rdCfg]};
      endcase
    end else if (s_axi_araddr == `RWS_STATUS) begin
      rdWord = {8'h0, bufCnt, 1'b0, state, 3'h0, cdrOn, pendB, pendA, cur, irqOut};
    end else if (s_axi_araddr == `RWS_CCA) begin
      rdWord = {16'h0, ccaReg};
    end else if (s_axi_araddr[7:4] == `RWS_BUF0 >> 4 && s_axi_araddr[1:0] == 2'h0) begin
      rdWord = bufReg[32*s_axi_araddr[3:2] +: 32];
    end else if (s_axi_araddr != `RWS_CMD) begin
      rdOk = 1'b0;
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdWord;
      s_axi_rresp <= rdOk ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // pin inputs pass two flip-flops
  reg [7:0] rssiMeta;
  reg [7:0] rssiSync;
  reg dataMeta;
  reg dataSync;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rssiMeta <= 8'h00;
      rssiSync <= 8'h00;
      dataMeta <= 1'b0;
      dataSync <= 1'b0;
    end else begin
      rssiMeta <= rssiLevel;
      rssiSync <= rssiMeta;
      dataMeta <= demodData;
      dataSync <= dataMeta;
    end
  end

  // selected configuration view
  wire [1:0] mode = ctlReg[cur][`RWS_MODE_LSB +: 2];
  wire cdrEn = ctlReg[cur][`RWS_CDREN_BIT];
  wire twoStage = ctlReg[cur][`RWS_TWOSTAGE_BIT];
  wire [3:0] thr = ctlReg[cur][`RWS_THR_LSB +: 4];
  wire [4:0] wLen = ctlReg[cur][`RWS_WLEN_LSB +: 5];
  wire [4:0] iLen = ctlReg[cur][`RWS_ILEN_LSB +: 5];
  wire [5:0] joinLen = {1'b0, wLen} + {1'b0, iLen};
  wire [15:0] wakePat = patternReg[cur][31:16];
  wire [15:0] chipPat = patternReg[cur][15:0];
  wire [31:0] joinPat = ({16'h0, wakePat} << iLen) | {16'h0, chipPat};
  wire isEnergy = mode == `RWS_MODE_ENERGY;
  wire sniffA = sniffReg[0] == `RWS_SNIFF_ON;
  wire sniffB = sniffReg[1] == `RWS_SNIFF_ON;

  // dwell tick, 8x oversample tick and bit tick dividers
  reg [23:0] tickCnt;
  reg dwellTick;
  reg [15:0] rateCnt;
  reg osTick;
  reg [2:0] phase;
  wire bitTick = osTick && phase == 3'h3;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tickCnt <= 24'h0;
      dwellTick <= 1'b0;
      rateCnt <= 16'h0;
      osTick <= 1'b0;
      phase <= 3'h0;
    end else begin
      dwellTick <= tickCnt == DWELL_TICK_CYCLES - 24'h1;
      tickCnt <= (tickCnt >= DWELL_TICK_CYCLES - 24'h1) ? 24'h0 : tickCnt + 24'h1;
      osTick <= rateCnt >= rateReg[cur];
      rateCnt <= (rateCnt >= rateReg[cur]) ? 16'h0 : rateCnt + 16'h1;
      if (osTick) begin
        phase <= phase + 3'h1;
      end
    end
  end

  // wake/joined correlator and chip id correlator share the sample stream
  reg corrClear;
  wire wakeMatch;
  wire chipMatch;
  rws_corr uWake (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .clear(corrClear),
    .sampleEn(osTick),
    .sample(dataSync),
    .pattern(isEnergy ? joinPat : {16'h0, wakePat}),
    .patLen(isEnergy ? joinLen : {1'b0, wLen}),
    .thr(thr),
    .match(wakeMatch)
  );
  rws_corr uChip (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .clear(corrClear),
    .sampleEn(osTick),
    .sample(dataSync),
    .pattern({16'h0, chipPat}),
    .patLen({1'b0, iLen}),
    .thr(thr),
    .match(chipMatch)
  );

  // a b cycle in code search or buffering must not be clobbered by a
  wire bBusy = cur && (state == S_CODE || state == S_BUF);
  // a timer that expires while its request is taken re-arms it, so no cycle is lost
  wire setA = sniffing && dwellTick && sniffA && timerA == 16'h0 && !bBusy;
  wire setB = sniffing && dwellTick && sniffB && timerB == 16'h0;
  wire endDwell = dwellTick && dwellCnt == 8'h00;
  wire endCode = dwellTick && codeCnt == 8'h00;
  wire finishPkt = pktLenReg[cur] != 8'h00;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_IDLE;
      cur <= 1'b0;
      sniffing <= 1'b0;
      pendA <= 1'b0;
      pendB <= 1'b0;
      timerA <= 16'h0;
      timerB <= 16'h0;
      ccaCnt <= 16'h0;
      ccaStrobe <= 1'b0;
      dwellCnt <= 8'h00;
      codeCnt <= 8'h00;
      bufCnt <= 8'h00;
      bufReg <= 128'h0;
      cdrOn <= 1'b0;
      irqOut <= 1'b0;
      corrClear <= 1'b1;
      rxEnable <= 1'b0;
      cdrEnable <= 1'b0;
      recoveredClockPin <= 1'b0;
      recoveredDataPin <= 1'b0;
      activeCfg <= 1'b0;
    end else begin
      corrClear <= 1'b0;
      ccaStrobe <= 1'b0;
      rxEnable <= state == S_CONT || state == S_SEARCH || state == S_CODE || state == S_BUF;
      cdrEnable <= cdrOn;
      activeCfg <= cur;
      recoveredDataPin <= cdrOn && dataSync;
      if (!cdrOn) begin
        recoveredClockPin <= 1'b0;
      end else if (osTick && phase[1:0] == 2'h3) begin
        recoveredClockPin <= ~phase[2];
      end
      // sniff interval timers, each with its own reload
      if (sniffing && dwellTick) begin
        ccaCnt <= (ccaCnt == 16'h0) ? ccaReg : ccaCnt - 16'h1;
        ccaStrobe <= ccaCnt == 16'h0;
        if (sniffA) begin
          timerA <= (timerA == 16'h0) ? intervalReg[0] : timerA - 16'h1;
          if (timerA == 16'h0 && !bBusy) begin
            pendA <= 1'b1;
          end
        end
        if (sniffB) begin
          timerB <= (timerB == 16'h0) ? intervalReg[1] : timerB - 16'h1;
          if (timerB == 16'h0) begin
            pendB <= 1'b1;
          end
        end
      end
      if (cmdStb) begin
        irqOut <= 1'b0;
        cdrOn <= 1'b0;
        corrClear <= 1'b1;
        sniffing <= 1'b0;
        pendA <= 1'b0;
        pendB <= 1'b0;
        state <= S_IDLE;
        if (cmdData[1:0] == `RWS_CMD_RECEIVE) begin
          cur <= cmdData[`RWS_CMD_CFG_BIT];
          dwellCnt <= rxDwellReg[cmdData[`RWS_CMD_CFG_BIT]];
          case (ctlReg[cmdData[`RWS_CMD_CFG_BIT]][1:0])
            `RWS_MODE_CONT: state <= S_CONT;
            `RWS_MODE_ENERGY: state <= S_SEARCH;
            `RWS_MODE_PATTERN: state <= S_SEARCH;
            default: state <= S_IDLE;
          endcase
        end else if (cmdData[1:0] == `RWS_CMD_SNIFF) begin
          sniffing <= 1'b1;
          state <= S_WAIT;
          pendA <= sniffA;
          pendB <= sniffB;
          timerA <= intervalReg[0];
          timerB <= intervalReg[1];
          ccaCnt <= ccaReg;
        end
      end else begin
        case (state)
          S_CONT: begin
            cdrOn <= cdrEn;
          end
          S_WAIT: begin
            if (pendA || pendB) begin
              cur <= !pendA;
              dwellCnt <= pendA ? rxDwellReg[0] : rxDwellReg[1];
              corrClear <= 1'b1;
              state <= S_SEARCH;
              if (pendA) begin
                pendA <= setA;
              end else begin
                pendB <= setB;
              end
            end
          end
          S_SEARCH: begin
            if (dwellTick && dwellCnt != 8'h00) begin
              dwellCnt <= dwellCnt - 8'h01;
            end
            if (cur && pendA) begin
              // a preempts a b search; b restarts after a
              pendB <= 1'b1;
              state <= S_WAIT;
            end else if (isEnergy && rssiSync > energyReg[cur]) begin
              cdrOn <= cdrEn;
              corrClear <= 1'b1;
              if (cdrEn && joinLen != 6'h0) begin
                codeCnt <= codeDwellReg[cur];
                state <= S_CODE;
              end else begin
                state <= finishPkt ? S_BUF : S_DONE;
                bufCnt <= pktLenReg[cur];
                irqOut <= !finishPkt;
              end
            end else if (mode == `RWS_MODE_PATTERN && wakeMatch) begin
              cdrOn <= 1'b1;
              if (twoStage) begin
                codeCnt <= codeDwellReg[cur];
                state <= S_CODE;
              end else begin
                state <= finishPkt ? S_BUF : S_DONE;
                bufCnt <= pktLenReg[cur];
                irqOut <= !finishPkt;
              end
            end else if ((isEnergy && rxDwellReg[cur] == 8'h00) || endDwell || mode[1] == mode[0]) begin
              cdrOn <= 1'b0;
              state <= sniffing ? S_WAIT : S_IDLE;
            end
          end
          S_CODE: begin
            if (dwellTick && codeCnt != 8'h00) begin
              codeCnt <= codeCnt - 8'h01;
            end
            if ((isEnergy && wakeMatch) || (!isEnergy && chipMatch)) begin
              state <= finishPkt ? S_BUF : S_DONE;
              bufCnt <= pktLenReg[cur];
              irqOut <= !finishPkt;
              if (!cur) begin
                pendB <= 1'b0;
              end else begin
                pendA <= 1'b0;
              end
            end else if (!isEnergy && wakeMatch) begin
              codeCnt <= codeDwellReg[cur];
            end else if (endCode) begin
              cdrOn <= 1'b0;
              state <= sniffing ? S_WAIT : S_IDLE;
            end
          end
          S_BUF: begin
            if (bitTick) begin
              bufReg <= {bufReg[126:0], dataSync};
              bufCnt <= bufCnt - 8'h01;
              if (bufCnt == 8'h01) begin
                irqOut <= 1'b1;
                state <= S_DONE;
              end
            end
          end
          S_DONE: begin
            sniffing <= 1'b0;
            pendA <= 1'b0;
            pendB <= 1'b0;
          end
          S_IDLE: begin
            cdrOn <= 1'b0;
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end
endmodule

// >>> bench/rws_rf_model.sv
// front-end stand-in: signal strength level and a repeating wake byte
`timescale 1ns/1ps
module rws_rf_model (
  input wire logic sys_clk,
  input wire logic sendEn,
  input wire logic energyHi,
  output logic [7:0] rssiLevel,
  output logic demodData
);
  localparam logic [7:0] WAKE_BYTE = 8'hA5;
  logic [5:0] phase_reg = 6'h00;
  always @(posedge sys_clk) phase_reg <= phase_reg + 6'h01;
  // eight clocks a bit; the byte reads the same both ways, so bit order cannot hide a fault
  assign demodData = sendEn & WAKE_BYTE[phase_reg[5:3]];
  assign rssiLevel = energyHi ? 8'hC0 : 8'h10;
endmodule

// >>> bench/rws_ctrl_assertions.sv
// port-level assertions for the receive wake/sniff controller
`timescale 1ns/1ps
`include "rws_regs.vh"
module rws_ctrl_assertions (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irqOut,
  input wire logic cdrEnable,
  input wire logic recoveredClockPin,
  input wire logic recoveredDataPin,
  input wire logic ccaStrobe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic [2:0] cmdAge_reg;
  // a command write may drop the interrupt a few cycles after it appears
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) cmdAge_reg <= 3'h0;
    else if (s_axi_awvalid && s_axi_awaddr == `RWS_CMD) cmdAge_reg <= 3'h0;
    else if (cmdAge_reg != 3'h7) cmdAge_reg <= cmdAge_reg + 3'h1;
  end
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_wr_resp;
    s_wr_take |=> !s_axi_awready ##[0:1] s_axi_bvalid;
  endproperty
  property p_rd_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
  endproperty
  property p_wr_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_irq_hold;
    irqOut && cmdAge_reg == 3'h7 |=> irqOut;
  endproperty
  property p_cdr_pins;
    !cdrEnable && !$past(cdrEnable) |-> !recoveredClockPin && !recoveredDataPin;
  endproperty
  property p_cca_pulse;
    ccaStrobe |=> !ccaStrobe;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
  a_rd_resp: assert property (p_rd_resp) else $error("read response late");
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
  a_r_hold: assert property (p_r_hold) else $error("rvalid dropped early");
  a_wr_busy: assert property (p_wr_busy) else $error("ready during response");
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without command");
  a_cdr_pins: assert property (p_cdr_pins) else $error("recovered pins active while off");
  a_cca_pulse: assert property (p_cca_pulse) else $error("cca strobe too long");
endmodule
bind rws_ctrl rws_ctrl_assertions i_chk (.*);

// >>> bench/rws_ctrl_tb.sv
// self-checking bench for the receive wake/sniff controller
`timescale 1ns/1ps
`include "rws_regs.vh"
module rws_ctrl_tb;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rssiLevel;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, sendEn = 1'b0, energyHi = 1'b0, prevRx = 1'b0, ccaSeen = 1'b0;
  logic rxSeen = 1'b0, pinSeen = 1'b0, bSeen = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, demodData, irqOut;
  logic rxEnable, cdrEnable, recoveredClockPin, recoveredDataPin, activeCfg, ccaStrobe;
  int err_total = 0, n_checks = 0, t, rises = 0;
  always #5 sys_clk = ~sys_clk;
  // four-clock dwell unit keeps every timer short
  rws_ctrl #(.DWELL_TICK_CYCLES(24'd4)) i_dut (.*);
  rws_rf_model i_fe (.*);
  function automatic logic [7:0] ra(input logic [3:0] i);
    return {2'b00, i, 2'b00};
  endfunction
  task automatic end_sim();
    if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chkb(input string n, input logic s, input logic e);
    chk(n, {31'h0, s}, {31'h0, e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      cyc(1);
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
      @(posedge sys_clk);
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    do cyc(1); while (!s_axi_bvalid);
    chk("bresp", {30'h0, s_axi_bresp}, 32'h0);
    // late bready lets the response-hold check see a stall
    @(posedge sys_clk);
    s_axi_bready <= 1'b1;
    @(posedge sys_clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do cyc(1); while (!s_axi_arready);
    @(posedge sys_clk);
    s_axi_arvalid <= 1'b0;
    do cyc(1); while (!s_axi_rvalid);
    r = s_axi_rresp;
    chk(n, s_axi_rdata, e);
    @(posedge sys_clk);
    s_axi_rready <= 1'b1;
    @(posedge sys_clk);
    s_axi_rready <= 1'b0;
  endtask
  initial begin
    #300000;
    err_total++;
    end_sim();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(ra(`RWS_RATE), `RWS_RATE_RST, "rate reset");
    rd(`RWS_CCA, `RWS_CCA_RST, "cca reset");
    rd(8'hFC, 32'h0, "unmapped data");
    chk("unmapped resp", {30'h0, r}, 32'h2);
    wr(ra(`RWS_RATE), 32'h0);
    wr(ra(`RWS_PATTERN), 32'hA5A5_A5A5);
    wr(`RWS_CFGB_BASE + ra(`RWS_CTL), 32'h1);
    rd(ra(`RWS_CTL), 32'h0, "cfg a untouched");
    wr(ra(`RWS_CTL), 32'h3);
    wr(`RWS_CMD, 32'h1);
    for (t = 0; t < 20; t++) begin
      cyc(1);
      rxSeen |= rxEnable;
    end
    chkb("reserved mode rx", rxSeen, 1'b0);
    wr(ra(`RWS_CTL), 32'h0);
    wr(`RWS_CMD, 32'h1);
    cyc(300);
    chkb("continuous rx", rxEnable, 1'b1);
    // threshold 8: a silent line must not pass for the joined pattern
    wr(ra(`RWS_CTL), 32'h885);
    wr(ra(`RWS_ENERGY), 32'h80);
    wr(ra(`RWS_RXDWELL), 32'h0);
    wr(`RWS_CMD, 32'h1);
    cyc(30);
    chkb("impulse rx", rxEnable, 1'b0);
    wr(ra(`RWS_RXDWELL), 32'hFF);
    wr(ra(`RWS_CODEDWELL), 32'h10);
    wr(`RWS_CMD, 32'h1);
    cyc(40);
    chkb("cdr before energy", cdrEnable, 1'b0);
    @(posedge sys_clk);
    energyHi <= 1'b1;
    for (t = 0; t < 50 && cdrEnable !== 1'b1; t++) cyc(1);
    chkb("cdr after energy", cdrEnable, 1'b1);
    @(posedge sys_clk);
    energyHi <= 1'b0;
    cyc(200);
    chkb("code dwell expiry", rxEnable, 1'b0);
    chkb("no wake on silence", irqOut, 1'b0);
    @(posedge sys_clk);
    sendEn <= 1'b1;
    // six of eight samples: tolerant of edge jitter yet no wake on a flat line
    wr(ra(`RWS_CTL), 32'h862);
    wr(`RWS_CMD, 32'h1);
    for (t = 0; t < 1000 && irqOut !== 1'b1; t++) cyc(1);
    chkb("pattern irq", irqOut, 1'b1);
    for (t = 0; t < 100; t++) begin
      cyc(1);
      pinSeen |= recoveredClockPin && recoveredDataPin;
    end
    chkb("recovered pins", pinSeen, 1'b1);
    chkb("irq held", irqOut, 1'b1);
    wr(`RWS_CMD, 32'h0);
    sendEn <= 1'b0;
    cyc(3);
    chkb("irq cleared", irqOut, 1'b0);
    wr(ra(`RWS_RXDWELL), 32'h1);
    wr(ra(`RWS_INTERVAL), 32'h3);
    wr(ra(`RWS_SNIFF), `RWS_SNIFF_ON);
    wr(`RWS_CFGB_BASE + ra(`RWS_ENERGY), 32'hFF);
    wr(`RWS_CFGB_BASE + ra(`RWS_SNIFF), `RWS_SNIFF_ON);
    wr(`RWS_CCA, 32'h2);
    wr(`RWS_CMD, 32'h2);
    for (t = 0; t < 400; t++) begin
      cyc(1);
      rises += int'(rxEnable && !prevRx);
      prevRx = rxEnable;
      ccaSeen |= ccaStrobe;
      bSeen |= activeCfg;
    end
    chkb("sniff rearm", rises > 1, 1'b1);
    chkb("cca strobe", ccaSeen, 1'b1);
    chkb("b cycle ran", bSeen, 1'b1);
    end_sim();
  end
endmodule
